//--- hdl/port_sampling_defines.vh
// Constants for the port input sampling and bulk pin configuration block
`ifndef PORT_SAMPLING_DEFINES_VH
`define PORT_SAMPLING_DEFINES_VH

// ---------------------------------------------------------------------
// Register offsets within one port group
// ---------------------------------------------------------------------
`define OFS_W               7
`define OFS_SAMPLED_LEVELS  7'h20
`define OFS_SAMPLE_MODE     7'h24
`define OFS_MULTI_PIN_CFG   7'h28
`define GROUP_SHIFT         7

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define RST_WORD            32'h00000000
`define RST_NIBBLE          4'h0
`define RST_BIT             1'b0
`define RST_SIZE            2'h0

// ---------------------------------------------------------------------
// Access size codes
// ---------------------------------------------------------------------
`define SIZE_BYTE           2'h0
`define SIZE_HALF           2'h1
`define SIZE_WORD           2'h2

// ---------------------------------------------------------------------
// Multi-pin configuration write fields
// ---------------------------------------------------------------------
`define CFG_HALF_WORD_SEL   31
`define CFG_PIN_SETTINGS_UPD 30
`define CFG_MUX_UPD         28
`define CFG_FUNC_HI         27
`define CFG_FUNC_LO         24
`define CFG_DRIVE_STRENGTH  22
`define CFG_PULL_ENABLE     18
`define CFG_INPUT_BUF_EN    17
`define CFG_MUX_ENABLE      16
`define CFG_MASK_HI         15
`define CFG_MASK_LO         0
`define HALF_PINS           16
`define FUNC_W              4

// ---------------------------------------------------------------------
// Sampler grouping
// ---------------------------------------------------------------------
`define SUBGROUP_PINS       8

`endif

//--- hdl/sampler_bank.v
// Pin input samplers, switched per byte between on-demand and continuous
`timescale 1ns/1ps
`include "port_sampling_defines.vh"

module sampler_bank #(
    parameter PINS = 32
) (
    input  wire              clk_i,
    input  wire              rst_n_i,
    input  wire [PINS-1:0]   pad_i,
    input  wire [PINS-1:0]   sample_mode_i,
    input  wire [PINS-1:0]   dir_i,
    input  wire              demand_i,
    output wire [PINS-1:0]   next_level_o,
    output reg  [PINS-1:0]   level_o,
    output wire [PINS/`SUBGROUP_PINS-1:0] byte_on_o
);

    localparam BYTES = PINS / `SUBGROUP_PINS;

    // -----------------------------------------------------------------
    // Per byte sampler enable and per pin capture
    // -----------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < BYTES; b = b + 1) begin : g_byte
            wire [`SUBGROUP_PINS-1:0] mode_b;
            wire [`SUBGROUP_PINS-1:0] dir_b;
            wire [`SUBGROUP_PINS-1:0] take_b;
            assign mode_b = sample_mode_i[b*`SUBGROUP_PINS +: `SUBGROUP_PINS];
            assign dir_b  = dir_i[b*`SUBGROUP_PINS +: `SUBGROUP_PINS];
            // Mode counts only on input pins; any one turns on the byte
            assign byte_on_o[b] = |(mode_b & ~dir_b);
            // Output pins are read back every cycle, mode does not apply
            assign take_b = {`SUBGROUP_PINS{byte_on_o[b] | demand_i}}
                          | dir_b;
            assign next_level_o[b*`SUBGROUP_PINS +: `SUBGROUP_PINS] =
                (take_b & pad_i[b*`SUBGROUP_PINS +: `SUBGROUP_PINS])
              | (~take_b & level_o[b*`SUBGROUP_PINS +: `SUBGROUP_PINS]);
        end
    endgenerate

    // Low pad clears the bit, high pad sets it
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            level_o <= {PINS{`RST_BIT}};
        end else begin
            level_o <= next_level_o;
        end
    end

endmodule // sampler_bank

//--- hdl/port_sampling_config.v
// Port group input sampling, sample mode and bulk pin configuration
`timescale 1ns/1ps
`include "port_sampling_defines.vh"

// What this block does
// - Sampled level bits follow pad level seen by sampler; read-only, reset zero.
// - Sample mode bit 0 gives on-demand sampling, 1 gives continuous.
// - Samplers switch per byte; one continuous pin makes whole byte continuous.
// - Sample mode only matters for pins configured as inputs.
// - Byte and half-word writes to the bulk config register are ignored.
// - Reading the bulk config register always returns zero.
// - Bit 31 picks lower sixteen pins when 0, upper sixteen when 1.
// - Bit 30 set loads strength, pull, input buffer, mux enable into selected pins.
// - Bit 30 clear leaves pin settings of selected pins unchanged.
// - One write applies identical settings and function to many pins at once.
// - Each group has its own registers, groups spaced 0x80 apart.
// - Sample mode and bulk config writes ignored while write-locked.
// - Bits 15..0 select pins of the chosen half; 0 leaves pin alone.
// - Bit 28 set loads function value from bits 27..24 into selected pins.
// - Strength bit 22, pull bit 18, input buffer bit 17, mux enable bit 16.
module port_sampling_config #(
    parameter ADDR_W      = 12,
    parameter GROUP_INDEX = 0,
    parameter PINS        = 32
) (
    input  wire                  clk_i,
    input  wire                  rst_n_i,
    input  wire [ADDR_W-1:0]     addr_i,
    input  wire [31:0]           wdata_i,
    input  wire [1:0]            size_i,
    input  wire                  wr_i,
    input  wire                  rd_i,
    output reg  [31:0]           rdata_o,
    input  wire                  write_lock_i,
    input  wire [PINS-1:0]       pad_i,
    input  wire [PINS-1:0]       dir_i,
    output reg  [PINS-1:0]       drive_strength_o,
    output reg  [PINS-1:0]       pull_resistor_enable_o,
    output reg  [PINS-1:0]       input_buffer_enable_o,
    output reg  [PINS-1:0]       peripheral_mux_enable_o,
    output reg  [PINS*4-1:0]     peripheral_function_select_o,
    output reg  [PINS/8-1:0]     sampler_continuous_o
);

    localparam BYTES = PINS / `SUBGROUP_PINS;

    // -----------------------------------------------------------------
    // Registers and wires
    // -----------------------------------------------------------------
    reg  [31:0]              sample_mode_reg;
    wire [PINS-1:0]          sampled_pad_levels;
    wire [PINS-1:0]          next_levels;
    wire [BYTES-1:0]         byte_on;
    wire                     group_hit;
    wire [`OFS_W-1:0]        offset;
    wire                     hit_levels;
    wire                     hit_mode;
    wire                     hit_cfg;
    wire                     mode_wr;
    wire                     cfg_wr;
    wire                     half_sel;
    wire                     upd_settings;
    wire                     upd_mux;
    wire [`FUNC_W-1:0]       func_val;
    wire [`HALF_PINS-1:0]    pin_select_mask;
    wire [31:0]              selected_pins;
    reg  [31:0]              next_rdata;

    // -----------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------
    // Upper address bits pick the group, lower bits the register
    assign group_hit = (addr_i[ADDR_W-1:`GROUP_SHIFT] ==
                        GROUP_INDEX[ADDR_W-`GROUP_SHIFT-1:0]);
    assign offset    = addr_i[`OFS_W-1:0];

    assign hit_levels = group_hit && (offset == `OFS_SAMPLED_LEVELS);
    assign hit_mode   = group_hit && (offset == `OFS_SAMPLE_MODE);
    assign hit_cfg    = group_hit && (offset == `OFS_MULTI_PIN_CFG);

    // Locked writes dropped silently
    assign mode_wr = wr_i && hit_mode && !write_lock_i;

    // Only whole-word writes reach the bulk configuration
    assign cfg_wr = wr_i && hit_cfg && !write_lock_i
                 && (size_i == `SIZE_WORD);

    // -----------------------------------------------------------------
    // Bulk configuration fields
    // -----------------------------------------------------------------
    assign half_sel        = wdata_i[`CFG_HALF_WORD_SEL];
    assign upd_settings    = wdata_i[`CFG_PIN_SETTINGS_UPD];
    assign upd_mux         = wdata_i[`CFG_MUX_UPD];
    assign func_val        = wdata_i[`CFG_FUNC_HI:`CFG_FUNC_LO];
    assign pin_select_mask = wdata_i[`CFG_MASK_HI:`CFG_MASK_LO];

    // Mask lands on the lower or upper half of the group
    assign selected_pins = half_sel ?
        {pin_select_mask, {`HALF_PINS{1'b0}}} :
        {{`HALF_PINS{1'b0}}, pin_select_mask};

    // -----------------------------------------------------------------
    // Sample mode register
    // -----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            sample_mode_reg <= `RST_WORD;
        end else if (mode_wr) begin
            sample_mode_reg <= wdata_i;
        end
    end

    // -----------------------------------------------------------------
    // Input samplers
    // -----------------------------------------------------------------
    // A read of the levels register is the on-demand sampling request
    sampler_bank #(
        .PINS          (PINS)
    ) u_sampler_bank (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .pad_i         (pad_i),
        .sample_mode_i (sample_mode_reg[PINS-1:0]),
        .dir_i         (dir_i),
        .demand_i      (rd_i && hit_levels),
        .next_level_o  (next_levels),
        .level_o       (sampled_pad_levels),
        .byte_on_o     (byte_on)
    );

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            sampler_continuous_o <= {BYTES{`RST_BIT}};
        end else begin
            sampler_continuous_o <= byte_on;
        end
    end

    // -----------------------------------------------------------------
    // Per pin settings and function select
    // -----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < PINS; p = p + 1) begin : g_pin
            wire take_settings;
            wire take_mux;
            // Same field values go to every selected pin in one write
            assign take_settings = cfg_wr && upd_settings
                                && selected_pins[p];
            assign take_mux      = cfg_wr && upd_mux
                                && selected_pins[p];

            always @(posedge clk_i) begin
                if (!rst_n_i) begin
                    drive_strength_o[p]        <= `RST_BIT;
                    pull_resistor_enable_o[p]  <= `RST_BIT;
                    input_buffer_enable_o[p]   <= `RST_BIT;
                    peripheral_mux_enable_o[p] <= `RST_BIT;
                end else if (take_settings) begin
                    drive_strength_o[p] <=
                        wdata_i[`CFG_DRIVE_STRENGTH];
                    pull_resistor_enable_o[p] <=
                        wdata_i[`CFG_PULL_ENABLE];
                    input_buffer_enable_o[p] <=
                        wdata_i[`CFG_INPUT_BUF_EN];
                    peripheral_mux_enable_o[p] <=
                        wdata_i[`CFG_MUX_ENABLE];
                end
            end

            always @(posedge clk_i) begin
                if (!rst_n_i) begin
                    peripheral_function_select_o[p*`FUNC_W +: `FUNC_W] <=
                        `RST_NIBBLE;
                end else if (take_mux) begin
                    peripheral_function_select_o[p*`FUNC_W +: `FUNC_W] <=
                        func_val;
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Read data
    // -----------------------------------------------------------------
    // On-demand read returns the level captured by this very read
    always @* begin
        next_rdata = `RST_WORD;
        if (rd_i) begin
            if (hit_levels) begin
                next_rdata = next_levels;
            end else if (hit_mode) begin
                next_rdata = sample_mode_reg;
            end else if (hit_cfg) begin
                next_rdata = `RST_WORD;
            end else begin
                next_rdata = `RST_WORD;
            end
        end
    end

    // Data stand for exactly one cycle after the read strobe
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= `RST_WORD;
        end else begin
            rdata_o <= next_rdata;
        end
    end

endmodule // port_sampling_config

//--- verification/pad_model.sv
// Pad model: commanded levels reach the port after a chosen lag
`timescale 1ns/1ps

module pad_model (
    input  wire        clk_i,
    input  wire [31:0] level_i,
    input  wire [3:0]  lag_i,
    output reg  [31:0] pad_o
);
    reg [3:0] wait_cnt = 4'h0;
    initial pad_o = 32'h00000000;
    // Slow pads settle lag_i+1 cycles after a change
    always @(posedge clk_i) begin
        if (level_i == pad_o || wait_cnt >= lag_i)
            wait_cnt <= 4'h0;
        else
            wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt >= lag_i)
            pad_o <= level_i;
    end
endmodule // pad_model

//--- verification/port_sampling_config_chk.sv
// Port assertions for the sampling and bulk configuration block
`timescale 1ns/1ps

module port_sampling_chk #(
    parameter ADDR_W      = 12,
    parameter GROUP_INDEX = 0,
    parameter PINS        = 32
) (
    input wire              clk_i,
    input wire              rst_n_i,
    input wire [ADDR_W-1:0] addr_i,
    input wire [31:0]       wdata_i,
    input wire [1:0]        size_i,
    input wire              wr_i,
    input wire              rd_i,
    input wire [31:0]       rdata_o,
    input wire              write_lock_i,
    input wire [PINS-1:0]   pad_i,
    input wire [PINS-1:0]   dir_i,
    input wire [PINS-1:0]   drive_strength_o,
    input wire [PINS-1:0]   pull_resistor_enable_o,
    input wire [PINS-1:0]   input_buffer_enable_o,
    input wire [PINS-1:0]   peripheral_mux_enable_o,
    input wire [PINS*4-1:0] peripheral_function_select_o,
    input wire [PINS/8-1:0] sampler_continuous_o
);
    wire              in_grp = addr_i[ADDR_W-1:7] == GROUP_INDEX;
    wire [6:0]        ofs    = addr_i[6:0];
    wire              rd_lvl = rd_i && in_grp && ofs == 7'h20;
    wire              rd_mode = rd_i && in_grp && ofs == 7'h24;
    wire              cfg_wr = wr_i && in_grp && ofs == 7'h28
                               && size_i == 2'h2 && !write_lock_i;
    wire [PINS-1:0]   sel    = wdata_i[31] ? {wdata_i[15:0], 16'h0000}
                                           : {16'h0000, wdata_i[15:0]};
    wire [PINS*4-1:0] fsel   = peripheral_function_select_o;
    wire [PINS*4-1:0] pins_all = {drive_strength_o, pull_resistor_enable_o,
                                  input_buffer_enable_o, peripheral_mux_enable_o};
    reg  [PINS-1:0]   mode;
    reg  [PINS/8-1:0] cont_exp;
    reg  [PINS*4-1:0] fs_want;
    integer           k;
    function [PINS-1:0] pick(input [PINS-1:0] o, input v);
        pick = (o & ~sel) | (sel & {PINS{v}});
    endfunction
    wire [PINS*4-1:0] pins_want = {pick(drive_strength_o, wdata_i[22]),
        pick(pull_resistor_enable_o, wdata_i[18]),
        pick(input_buffer_enable_o, wdata_i[17]),
        pick(peripheral_mux_enable_o, wdata_i[16])};
    // Shadow of the sample mode register
    always @(posedge clk_i) begin
        if (!rst_n_i)
            mode <= {PINS{1'b0}};
        else if (wr_i && in_grp && ofs == 7'h24 && !write_lock_i)
            mode <= wdata_i;
    end
    always @* begin
        fs_want = fsel;
        for (k = 0; k < PINS; k = k + 1) begin
            if (sel[k])
                fs_want[4*k+:4] = wdata_i[27:24];
            if (k % 8 == 0)
                cont_exp[k/8] = |(mode[k+:8] & ~dir_i[k+:8]);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_pin_upd; cfg_wr && wdata_i[30]; endsequence
    sequence s_mux_upd; cfg_wr && wdata_i[28]; endsequence
    property p_lvl_rd; rd_lvl && $stable(pad_i) |=> rdata_o == $past(pad_i);
    endproperty
    a_lvl_rd: assert property (p_lvl_rd) else $error("level read");
    property p_mode_rd; rd_mode |=> rdata_o == $past(mode);
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode read");
    property p_rd_zero; !(rd_lvl || rd_mode) |=> rdata_o == 32'h00000000;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read not zero");
    property p_cont; 1'b1 |=> sampler_continuous_o == $past(cont_exp);
    endproperty
    a_cont: assert property (p_cont) else $error("sampler byte");
    property p_pin_upd; s_pin_upd |=> pins_all == $past(pins_want);
    endproperty
    a_pin_upd: assert property (p_pin_upd) else $error("pin load");
    property p_mux_upd; s_mux_upd |=> fsel == $past(fs_want);
    endproperty
    a_mux_upd: assert property (p_mux_upd) else $error("mux load");
    property p_pin_hold; !(cfg_wr && wdata_i[30]) |=> $stable(pins_all);
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin hold");
    property p_mux_hold; !(cfg_wr && wdata_i[28]) |=> $stable(fsel);
    endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("mux hold");
endmodule // port_sampling_chk

bind port_sampling_config port_sampling_chk #(
    .ADDR_W(ADDR_W), .GROUP_INDEX(GROUP_INDEX), .PINS(PINS)
) u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .size_i(size_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .write_lock_i(write_lock_i), .pad_i(pad_i), .dir_i(dir_i),
    .drive_strength_o(drive_strength_o),
    .pull_resistor_enable_o(pull_resistor_enable_o),
    .input_buffer_enable_o(input_buffer_enable_o),
    .peripheral_mux_enable_o(peripheral_mux_enable_o),
    .peripheral_function_select_o(peripheral_function_select_o),
    .sampler_continuous_o(sampler_continuous_o));

//--- verification/tb_top.sv
// Self-checking bench for the port sampling and bulk configuration block
`timescale 1ns/1ps

module tb_top;
    reg          clk_i, rst_n_i, wr_i, rd_i, write_lock_i;
    reg  [11:0]  addr_i;
    reg  [1:0]   size_i;
    reg  [3:0]   lag;
    reg  [31:0]  wdata_i, dir_i, level, q, m, e_mode, e_ds, e_pu, e_ib, e_me;
    reg  [127:0] e_fs;
    wire [31:0]  rdata_o, pad_i, ds, pu, ib, me;
    wire [127:0] fs;
    wire [3:0]   cont;
    integer      fails = 0, comparisons = 0, cycles = 0, i, j;
    port_sampling_config #(.ADDR_W(12), .GROUP_INDEX(1), .PINS(32)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .size_i(size_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .write_lock_i(write_lock_i), .pad_i(pad_i), .dir_i(dir_i),
        .drive_strength_o(ds), .pull_resistor_enable_o(pu),
        .input_buffer_enable_o(ib), .peripheral_mux_enable_o(me),
        .peripheral_function_select_o(fs), .sampler_continuous_o(cont));
    pad_model pads (.clk_i(clk_i), .level_i(level), .lag_i(lag), .pad_o(pad_i));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            complete_run;
        end
    end
    task complete_run;
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input [127:0] e, input [127:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task bus(input w, input [11:0] a, input [31:0] d, input [1:0] s);
        @(posedge clk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        size_i <= s;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1 q = rdata_o;
    endtask
    function [31:0] upd(input [31:0] o, input [31:0] d, input v);
        reg [31:0] s;
        s = d[31] ? {d[15:0], 16'h0000} : {16'h0000, d[15:0]};
        upd = (o & ~s) | (s & {32{v}});
    endfunction
    task cfg(input [11:0] a, input [31:0] d, input [1:0] s);
        bus(1'b1, a, d, s);
        m = upd(32'h00000000, d, 1'b1);
        if (a == 12'h0A8 && s == 2'h2 && !write_lock_i) begin
            if (d[30]) begin
                e_ds = upd(e_ds, d, d[22]);
                e_pu = upd(e_pu, d, d[18]);
                e_ib = upd(e_ib, d, d[17]);
                e_me = upd(e_me, d, d[16]);
            end
            for (j = 0; j < 32; j = j + 1)
                if (d[28] && m[j])
                    e_fs[4*j+:4] = d[27:24];
        end
        chk("pins", {e_ds, e_pu, e_ib, e_me}, {ds, pu, ib, me});
        chk("function", e_fs, fs);
        bus(1'b0, 12'h0A8, 32'h00000000, 2'h2);
        chk("config read", 32'h00000000, q);
    endtask
    task mode_wr(input [31:0] d, input [1:0] s);
        bus(1'b1, 12'h0A4, d, s);
        if (!write_lock_i)
            e_mode = d;
        bus(1'b0, 12'h0A4, 32'h00000000, 2'h2);
        chk("mode", e_mode, q);
        for (j = 0; j < 4; j = j + 1)
            m[j] = |(e_mode[8*j+:8] & ~dir_i[8*j+:8]);
        chk("continuous", m[3:0], cont);
        bus(1'b0, 12'h024, 32'h00000000, 2'h2);
        chk("other group", 32'h00000000, q);
    endtask
    task lvl(input [31:0] v);
        level <= v;
        repeat (8) @(posedge clk_i);
        bus(1'b0, 12'h0A0, 32'h00000000, 2'h2);
        chk("levels", v, q);
    endtask
    initial begin
        {wr_i, rd_i, write_lock_i, rst_n_i, addr_i, size_i, lag} = 0;
        {wdata_i, dir_i, level, e_mode, e_ds, e_pu, e_ib, e_me, e_fs} = 0;
        q = $urandom(58599);
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        lvl(32'h00000000);
        mode_wr(32'h00000100, 2'h2);
        mode_wr(32'h81000001, 2'h0);
        @(posedge clk_i) dir_i <= 32'hFF000000;
        mode_wr(32'h81000001, 2'h1);
        @(posedge clk_i) write_lock_i <= 1'b1;
        mode_wr(32'h0000FFFF, 2'h2);
        cfg(12'h0A8, 32'h4047FFFF, 2'h2);
        @(posedge clk_i) write_lock_i <= 1'b0;
        for (i = 0; i < 12; i = i + 1) begin
            @(posedge clk_i) dir_i <= $urandom;
            lag <= $urandom % 4;
            mode_wr($urandom, 2'h2);
            lvl($urandom);
        end
        cfg(12'h0A8, 32'h4047FFFF, 2'h2);
        cfg(12'h0A8, 32'hD5F08001, 2'h2);
        cfg(12'h0A8, 32'h0F47FFFF, 2'h2);
        cfg(12'h0A8, 32'h5F00FFFF, 2'h1);
        cfg(12'h028, 32'h5F00FFFF, 2'h2);
        for (i = 0; i < 60; i = i + 1) begin
            @(posedge clk_i) write_lock_i <= ($urandom % 4) == 0;
            cfg(($urandom % 5) ? 12'h0A8 : 12'h028, $urandom, $urandom % 3);
        end
        complete_run;
    end
endmodule // tb_top
